// ==== core/nip_pkg.sv ====
/*
 * Shared constants of the nested interrupt priority controller.
 * Assumes a single core clock domain; imported whole by every module except nip_core_model.
 */
package nip_pkg;
   // Default number of maskable request sources
   localparam int NIP_SRC_DEFAULT = 8;
   // Priority field: two bits, level 0 is the highest
   localparam int NIP_LVL_W = 2;
   localparam int NIP_NUM_LVL = 4;
   localparam logic [1:0] NIP_LVL_HIGHEST = 2'h0;
   localparam logic [1:0] NIP_LVL_LOWEST = 2'h3;
   // Current service level when nothing is in service (below every level)
   localparam logic [2:0] NIP_CUR_NONE = 3'h4;
   // Reset values
   localparam logic NIP_ACK_EN_RESET = 1'b0;
   localparam logic [3:0] NIP_INSERV_RESET = 4'h0;
endpackage

// ==== core/nip_arb.sv ====
/*
 * Combinational priority arbiter: picks the pending source with the
 * highest priority level, lowest index on a tie.
 * Assumes pending flags and priority bits come from flops on the same clock.
 */
`timescale 1ns/10ps
module nip_arb
   import nip_pkg::*;
#(
   parameter int NUM_SRC = NIP_SRC_DEFAULT,
   parameter int IDX_W = $clog2(NUM_SRC)
) (
   input wire logic [NUM_SRC-1:0] reqPending,
   input wire logic [NUM_SRC-1:0] priorityUpperBit,
   input wire logic [NUM_SRC-1:0] priorityLowerBit,
   output logic winValid,
   output logic [IDX_W-1:0] winIdx,
   output logic [NIP_LVL_W-1:0] winLevel
);
   logic [NIP_LVL_W-1:0] srcLevel [NUM_SRC];

   // Upper bit and lower bit come from separate flag vectors
   for (genvar g = 0; g < NUM_SRC; g++) begin : gLevel
      assign srcLevel[g] = {priorityUpperBit[g], priorityLowerBit[g]};
   end

   // Strict less-than keeps the lowest index on equal levels
   always_comb begin
      winValid = 1'b0;
      winIdx = '0;
      winLevel = NIP_LVL_LOWEST;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (reqPending[i] && (!winValid || srcLevel[i] < winLevel)) begin
            winValid = 1'b1;
            winIdx = IDX_W'(i);
            winLevel = srcLevel[i];
         end
      end
   end
endmodule

// ==== core/nip_ctrl.sv ====
/*
 * Nested interrupt priority controller, top level.
 * Holds pending requests, the global acknowledge enable, the stack of
 * in-service levels and the one-instruction hold-off after a return.
 * A return sets the enable again, as every routine was entered with it set.
 * Assumes the core reports instruction boundaries and the enable, disable
 * and return instructions as one-cycle pulses on core_clk, and that
 * peripheral requests are one-cycle pulses from logic on the same clock.
 */
`timescale 1ns/10ps
module nip_ctrl
   import nip_pkg::*;
#(
   parameter int NUM_SRC = NIP_SRC_DEFAULT,
   parameter int IDX_W = $clog2(NUM_SRC)
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [NUM_SRC-1:0] intReq,
   input wire logic [NUM_SRC-1:0] priorityUpperBit,
   input wire logic [NUM_SRC-1:0] priorityLowerBit,
   input wire logic enableIntrInstr,
   input wire logic disableIntrInstr,
   input wire logic retiInstr,
   input wire logic instrBoundary,
   output logic intAck,
   output logic [IDX_W-1:0] ackSource,
   output logic [NIP_LVL_W-1:0] ackLevel,
   output logic [NIP_NUM_LVL-1:0] inService,
   output logic globalAckEnableFlag,
   output logic [NUM_SRC-1:0] reqPending,
   output logic holdOff
);
   logic winValid;
   logic [IDX_W-1:0] winIdx;
   logic [NIP_LVL_W-1:0] winLevel;
   logic [2:0] curLevel;
   logic takeAck;
   logic [NIP_NUM_LVL-1:0] retireMask;

   nip_arb #(
      .NUM_SRC(NUM_SRC),
      .IDX_W(IDX_W)
   ) uArb (
      .reqPending(reqPending),
      .priorityUpperBit(priorityUpperBit),
      .priorityLowerBit(priorityLowerBit),
      .winValid(winValid),
      .winIdx(winIdx),
      .winLevel(winLevel)
   );

   // Current service level is the highest level still in service
   // Idle counts as level 4, so any real level compares as higher
   always_comb begin
      curLevel = NIP_CUR_NONE;
      retireMask = '0;
      for (int l = NIP_NUM_LVL - 1; l >= 0; l--) begin
         if (inService[l]) begin
            curLevel = 3'(l);
         end
      end
      if (curLevel != NIP_CUR_NONE) begin
         retireMask[curLevel[NIP_LVL_W-1:0]] = 1'b1;
      end
   end

   // Acknowledge only at an instruction boundary, never in a return cycle
   assign takeAck = instrBoundary && globalAckEnableFlag && !holdOff
      && !retiInstr && winValid
      && ({1'b0, winLevel} < curLevel);

   // Sticky pending flags; a new request wins over its own acknowledge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reqPending <= '0;
      end else begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (intReq[i]) begin
               reqPending[i] <= 1'b1;
            end else if (takeAck && winIdx == IDX_W'(i)) begin
               reqPending[i] <= 1'b0;
            end
         end
      end
   end

   // Acknowledge clears the enable; the enable instruction or a return sets it.
   // Return brings back the enable the routine was entered with, which is
   // always set; otherwise a request held during a plain routine would starve.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         globalAckEnableFlag <= NIP_ACK_EN_RESET;
      end else if (takeAck) begin
         globalAckEnableFlag <= 1'b0;
      end else if (retiInstr) begin
         globalAckEnableFlag <= 1'b1;
      end else if (enableIntrInstr) begin
         globalAckEnableFlag <= 1'b1;
      end else if (disableIntrInstr) begin
         globalAckEnableFlag <= 1'b0;
      end
   end

   // In-service stack, one bit per level; return retires the top level
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         inService <= NIP_INSERV_RESET;
      end else if (retiInstr) begin
         inService <= inService & ~retireMask;
      end else if (takeAck) begin
         inService[winLevel] <= 1'b1;
      end
   end

   // After a return one instruction must complete before the next acknowledge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         holdOff <= 1'b0;
      end else if (retiInstr) begin
         holdOff <= 1'b1;
      end else if (instrBoundary) begin
         holdOff <= 1'b0;
      end
   end

   // Registered acknowledge; source and level hold until the next one
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         intAck <= 1'b0;
         ackSource <= '0;
         ackLevel <= NIP_LVL_HIGHEST;
      end else begin
         intAck <= takeAck;
         if (takeAck) begin
            ackSource <= winIdx;
            ackLevel <= winLevel;
         end
      end
   end

   // Checks on the acknowledge decision
   nest_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instrBoundary && globalAckEnableFlag && !holdOff && !retiInstr && winValid
       && curLevel != NIP_CUR_NONE && {1'b0, winLevel} < curLevel)
      |=> intAck && $countones(inService) >= 2)
      else $error("higher priority request not nested");

   enable_rearm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (intAck && !enableIntrInstr && !retiInstr) |-> !globalAckEnableFlag ##1 !globalAckEnableFlag)
      else $error("second acknowledge without enable instruction");

   low_refuse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (curLevel != NIP_CUR_NONE && !retiInstr && {1'b0, winLevel} >= curLevel)
      |=> !intAck)
      else $error("equal or lower priority request acknowledged");

   one_instr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      retiInstr ##1 (!instrBoundary || retiInstr) |=> !intAck ##1 !intAck)
      else $error("acknowledge before one main instruction ran");

   pend_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (winValid && !takeAck) |=> reqPending[$past(winIdx)])
      else $error("refused request lost its pending flag");

   prio_enc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      winValid |-> winLevel == {priorityUpperBit[winIdx], priorityLowerBit[winIdx]})
      else $error("priority level not formed from upper and lower flags");

   ack_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !globalAckEnableFlag |=> !intAck)
      else $error("acknowledge while enable flag clear");

   // Checks on the return hold-off, the paths that must acknowledge, pending set and the acknowledge outputs
   hold_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      retiInstr |=> holdOff && !intAck)
      else $error("return did not start the hold-off");

   hold_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      holdOff |=> !intAck)
      else $error("acknowledge during the hold-off");

   held_take_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (holdOff && instrBoundary && !retiInstr)
      ##1 (instrBoundary && globalAckEnableFlag && !retiInstr && winValid && curLevel == NIP_CUR_NONE)
      |=> intAck)
      else $error("held request not taken after one main instruction");

   pend_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (|intReq) |=> (reqPending & $past(intReq)) == $past(intReq))
      else $error("request did not become pending");

   enable_take_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (instrBoundary && globalAckEnableFlag && !holdOff && !retiInstr && winValid
       && curLevel == NIP_CUR_NONE)
      |=> intAck && !globalAckEnableFlag)
      else $error("enabled request not acknowledged");

   ack_single_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      intAck |=> !intAck)
      else $error("two acknowledges without an enable between");

   service_mark_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      intAck |-> inService[ackLevel])
      else $error("acknowledged level not marked in service");

   // Scenario covers: nesting once and twice, held request, blocked, return
   nest_twice_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      intAck && $countones(inService) == 3);

   held_low_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      retiInstr && winValid ##[1:20] intAck);

   blocked_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      instrBoundary && winValid && !globalAckEnableFlag);

   nest_once_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      intAck && $countones(inService) == 2);

   return_enable_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      retiInstr && !globalAckEnableFlag ##1 globalAckEnableFlag);
endmodule

// ==== dv/nip_core_model.sv ====
/* Core-side model: hands instruction-boundary pulses to the controller.
   Assumes the bench starts it after reset and picks the pace. */
`timescale 1ns/10ps
module nip_core_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic slow,
   output logic instrBoundary
);
   // Slow pace skips every other boundary, like two-cycle instructions
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         instrBoundary <= 1'b0;
      end else begin
         instrBoundary <= run & ~(slow & instrBoundary);
      end
   end
endmodule

// ==== dv/nested_interrupt_priority_bench.sv ====
/* Self-checking bench for the nested interrupt controller.
   Assumes eight sources; the core model makes the boundaries. */
`timescale 1ns/10ps
module nested_interrupt_priority_bench
   import nip_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] intReq = 8'h00;
   logic [7:0] upBit = 8'h82;
   logic [7:0] loBit = 8'h88;
   logic enInstr = 1'b0, di = 1'b0, reti = 1'b0, run = 1'b0, slow = 1'b0;
   logic instrBoundary, intAck, flag, holdOff;
   logic [2:0] ackSource;
   logic [1:0] ackLevel;
   logic [3:0] inService;
   logic [7:0] pending;
   int num_errors = 0;
   int tests_run = 0;

   // 40 MHz core clock
   always #12.5 core_clk = ~core_clk;

   nip_ctrl #(.NUM_SRC(8)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .intReq(intReq),
      .priorityUpperBit(upBit), .priorityLowerBit(loBit), .enableIntrInstr(enInstr),
      .disableIntrInstr(di), .retiInstr(reti), .instrBoundary(instrBoundary), .intAck(intAck),
      .ackSource(ackSource), .ackLevel(ackLevel), .inService(inService),
      .globalAckEnableFlag(flag), .reqPending(pending), .holdOff(holdOff));

   nip_core_model u_core (.core_clk(core_clk), .rst_n(rst_n), .run(run), .slow(slow),
      .instrBoundary(instrBoundary));

   // Inputs move 1 ns after the edge, so no race with the design
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask

   task automatic pulseReq(input int src);
      intReq[src] = 1'b1;
      tick(1);
      intReq = 8'h00;
   endtask

   // Bounded wait, then judge the acknowledge
   task automatic waitAck(input logic [2:0] src, input logic [1:0] lvl);
      for (int i = 0; i < 6 && intAck !== 1'b1; i++) tick(1);
      check(intAck, 8'h01);
      check(ackSource, src);
      check(ackLevel, lvl);
      check(flag, 8'h00);
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Enable off: request stays pending, then enable lets it through
   task automatic testEnableGate;
      rst_n = 1'b0;
      tick(20);
      rst_n = 1'b1;
      check(flag, 8'h00);
      check(inService, 8'h00);
      run = 1'b1;
      pulse(enInstr);
      pulse(di);
      pulseReq(1);
      tick(4);
      check(intAck, 8'h00);
      check(pending[1], 8'h01);
      pulse(enInstr);
      waitAck(3'h1, 2'h2);
      check(inService, 8'h04);
      $display("test enable gate done");
   endtask

   // Two nested levels, each needing a fresh enable, at slow pace
   task automatic testNesting;
      slow = 1'b1;
      pulseReq(3);
      tick(4);
      check(intAck, 8'h00);
      pulse(enInstr);
      waitAck(3'h3, 2'h1);
      pulse(enInstr);
      pulseReq(5);
      waitAck(3'h5, 2'h0);
      check(inService, 8'h07);
      $display("test nesting done");
   endtask

   // Lower level held until return plus one main instruction
   task automatic testHeld;
      slow = 1'b0;
      pulse(enInstr);
      pulseReq(7);
      tick(4);
      check(intAck, 8'h00);
      check(pending[7], 8'h01);
      // Three returns in a row unwind all three levels
      reti = 1'b1;
      tick(3);
      reti = 1'b0;
      check(holdOff, 8'h01);
      check(intAck, 8'h00);
      tick(1);
      check(intAck, 8'h00);
      tick(1);
      check(intAck, 8'h01);
      check(ackSource, 8'h07);
      check(flag, 8'h00);
      pulse(reti);
      check(flag, 8'h01);
      check(inService, 8'h00);
      $display("test held request done");
   endtask

   initial begin
      testEnableGate;
      testNesting;
      testHeld;
      finish_test;
   end

   // Watchdog at 4000 cycles, far beyond the fewer than one hundred cycles the tests need
   initial begin
      #100000;
      num_errors++;
      finish_test;
   end
endmodule
